/* File: verilog/dpfis_pkg.sv */
// Constants and types shared by the performance filter and interrupt status block
package dpfis_pkg;

  // ************************************************************
  // Bus and register map
  // ************************************************************
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DEC_W = 8;

  localparam logic [DEC_W-1:0] OFS_SELECT = 8'h00;
  localparam logic [DEC_W-1:0] OFS_ELAPSED = 8'h04;
  localparam logic [DEC_W-1:0] OFS_RAW = 8'h08;
  localparam logic [DEC_W-1:0] OFS_ENABLED = 8'h0C;
  localparam logic [DEC_W-1:0] OFS_EN_SET = 8'h10;
  localparam logic [DEC_W-1:0] OFS_EN_CLR = 8'h14;

  // ************************************************************
  // Filter select field layout
  // ************************************************************
  localparam int unsigned MST_W = 8;
  localparam int unsigned REG_W = 4;
  localparam int unsigned POS_MST2 = 24;
  localparam int unsigned POS_REG2 = 16;
  localparam int unsigned POS_MST1 = 8;
  localparam int unsigned POS_REG1 = 0;
  localparam logic [MST_W-1:0] RST_MST = 8'h00;
  localparam logic [REG_W-1:0] RST_REG = 4'h0;
  localparam logic [REG_W-1:0] REGION_EXT_MEM = 4'h0;
  localparam logic [REG_W-1:0] REGION_CTRL_REGS = 4'h7;

  // ************************************************************
  // Interrupt flag layout
  // ************************************************************
  localparam int unsigned POS_SBE = 5;
  localparam int unsigned POS_DBE = 4;
  localparam int unsigned POS_WRE = 3;
  localparam int unsigned POS_BUS = 0;
  localparam logic [DATA_W-1:0] FLAG_MASK = 32'h0000_0039;
  localparam logic [DATA_W-1:0] RST_FLAGS = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_ENABLES = 32'h0000_0000;

  // ************************************************************
  // Elapsed time counter
  // ************************************************************
  localparam logic [DATA_W-1:0] RST_ELAPSED = 32'h0000_0000;
  localparam int unsigned HALF_RATE_DIV = 1;

  // ************************************************************
  // Bus slave states
  // ************************************************************
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ_WAIT = 2'b10,
    BUS_READ_DONE = 2'b11
  } dpfis_bus_state_t;

endpackage : dpfis_pkg

/* File: verilog/dpfis_tick_div.sv */
// Divider that makes the one-cycle tick of the elapsed time counter
`timescale 1ns/100ps
module dpfis_tick_div #(
  parameter int unsigned DIV = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  output logic tick
);
  import dpfis_pkg::*;

  localparam int unsigned CNT_W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(DIV - 1);

  logic [CNT_W-1:0] cnt;

  if (DIV < 1) begin : g_bad_div
    $error("dpfis_tick_div: DIV must be at least 1");
  end

  // ************************************************************
  // Cycle count and tick
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= '0;
    end else if (cnt == LAST) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick <= 1'b0;
    end else begin
      tick <= (cnt == LAST);
    end
  end

endmodule : dpfis_tick_div

/* File: verilog/dpfis_top.sv */
// Performance filter select, elapsed time counter and error interrupt status over AHB-Lite
//
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
module dpfis_top #(
  parameter int unsigned TICK_DIV = dpfis_pkg::HALF_RATE_DIV
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [dpfis_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [dpfis_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic [dpfis_pkg::DATA_W-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic single_bit_ecc_event,
  input wire logic double_bit_ecc_event,
  input wire logic write_path_ecc_event,
  input wire logic bus_cmd_addr_error_event,
  output logic [dpfis_pkg::MST_W-1:0] counter_one_master_filter,
  output logic [dpfis_pkg::REG_W-1:0] counter_one_region_filter,
  output logic [dpfis_pkg::MST_W-1:0] counter_two_master_filter,
  output logic [dpfis_pkg::REG_W-1:0] counter_two_region_filter,
  output logic irq
);
  import dpfis_pkg::*;

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (TICK_DIV < 1) begin : g_bad_div
    $error("dpfis_top: TICK_DIV must be at least 1");
  end
  if (DEC_W > ADDR_W) begin : g_bad_dec
    $error("dpfis_top: offset decode wider than the address");
  end
  if (POS_MST2 + MST_W > DATA_W) begin : g_bad_mst2
    $error("dpfis_top: master two field leaves the word");
  end
  if (POS_REG2 + REG_W > POS_MST2) begin : g_bad_reg2
    $error("dpfis_top: region two field overlaps master two");
  end
  if (POS_MST1 + MST_W > POS_REG2) begin : g_bad_mst1
    $error("dpfis_top: master one field overlaps region two");
  end
  if (POS_REG1 + REG_W > POS_MST1) begin : g_bad_reg1
    $error("dpfis_top: region one field overlaps master one");
  end
  if (!FLAG_MASK[POS_SBE] || !FLAG_MASK[POS_DBE] || !FLAG_MASK[POS_WRE]
      || !FLAG_MASK[POS_BUS]) begin : g_bad_mask
    $error("dpfis_top: flag mask misses a source position");
  end

  // ************************************************************
  // Declarations
  // ************************************************************
  dpfis_bus_state_t state;
  dpfis_bus_state_t next_state;
  logic accept;
  logic [DEC_W-1:0] addr_q;
  logic wr_phase;
  logic wr_select;
  logic wr_raw;
  logic wr_enabled;
  logic wr_en_set;
  logic wr_en_clr;
  logic [DATA_W-1:0] raw_flags;
  logic [DATA_W-1:0] enables;
  logic [DATA_W-1:0] enabled_flags;
  logic [DATA_W-1:0] hw_events;
  logic [DATA_W-1:0] elapsed;
  logic [DATA_W-1:0] read_value;
  logic [DATA_W-1:0] select_value;
  logic tick;

  // ************************************************************
  // Elapsed time tick, every cycle at the default divide
  // ************************************************************
  // With the default divide of one the tick is high in every cycle
  // after the first edge out of reset.
  dpfis_tick_div #(
    .DIV(TICK_DIV)
  ) u_tick_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick)
  );

  // ************************************************************
  // Bus slave handshake
  // ************************************************************
  // Transfers are taken only while the bus is ready; the size is not
  // checked, every access acts on a whole word.
  assign accept = hsel & htrans[1] & hready;

  // An address phase leads to a write data phase or to the read wait;
  // the read wait is always left after one cycle.
  always_comb begin
    next_state = state;
    unique case (state)
      BUS_IDLE, BUS_WRITE, BUS_READ_DONE: begin
        if (accept) begin
          next_state = hwrite ? BUS_WRITE : BUS_READ_WAIT;
        end else begin
          next_state = BUS_IDLE;
        end
      end
      BUS_READ_WAIT: begin
        next_state = BUS_READ_DONE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= BUS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= '0;
    end else if (accept) begin
      addr_q <= haddr[DEC_W-1:0];
    end
  end

  // Reads take one wait state so that they see a write just before them
  assign hreadyout = (state != BUS_READ_WAIT);
  assign hresp = 1'b0;

  // ************************************************************
  // Write decode
  // ************************************************************
  // Writes act at the end of their data phase, decoded from the
  // registered address.
  assign wr_phase = (state == BUS_WRITE);
  assign wr_select = wr_phase && (addr_q == OFS_SELECT);
  assign wr_raw = wr_phase && (addr_q == OFS_RAW);
  assign wr_enabled = wr_phase && (addr_q == OFS_ENABLED);
  assign wr_en_set = wr_phase && (addr_q == OFS_EN_SET);
  assign wr_en_clr = wr_phase && (addr_q == OFS_EN_CLR);

  // ************************************************************
  // Filter select register
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      counter_two_master_filter <= RST_MST;
    end else if (wr_select) begin
      counter_two_master_filter <= hwdata[POS_MST2 +: MST_W];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      counter_one_master_filter <= RST_MST;
    end else if (wr_select) begin
      counter_one_master_filter <= hwdata[POS_MST1 +: MST_W];
    end
  end

  // Reserved encodings are stored as written; the counters decide
  // what they mean.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      counter_two_region_filter <= RST_REG;
    end else if (wr_select) begin
      counter_two_region_filter <= hwdata[POS_REG2 +: REG_W];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      counter_one_region_filter <= RST_REG;
    end else if (wr_select) begin
      counter_one_region_filter <= hwdata[POS_REG1 +: REG_W];
    end
  end

  always_comb begin
    select_value = '0;
    select_value[POS_MST2 +: MST_W] = counter_two_master_filter;
    select_value[POS_REG2 +: REG_W] = counter_two_region_filter;
    select_value[POS_MST1 +: MST_W] = counter_one_master_filter;
    select_value[POS_REG1 +: REG_W] = counter_one_region_filter;
  end

  // ************************************************************
  // Elapsed time counter
  // ************************************************************
  // Wraps at the top and is never written by software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      elapsed <= RST_ELAPSED;
    end else if (tick) begin
      elapsed <= elapsed + 32'h0000_0001;
    end
  end

  // ************************************************************
  // Error events
  // ************************************************************
  // The sources run on this clock and need no synchroniser; every
  // cycle an event is high sets its flag again.
  always_comb begin
    hw_events = '0;
    hw_events[POS_SBE] = single_bit_ecc_event;
    hw_events[POS_DBE] = double_bit_ecc_event;
    hw_events[POS_WRE] = write_path_ecc_event;
    hw_events[POS_BUS] = bus_cmd_addr_error_event;
  end

  // ************************************************************
  // Raw flags and source enables, one bit slice each
  // ************************************************************
  // Only the four source positions hold flops; the other bits of the
  // raw flags and enables are tied low, so reserved bits read zero
  // and ignore writes.
  for (genvar g = 0; g < DATA_W; g++) begin : g_flag
    if (FLAG_MASK[g]) begin : g_src
      logic raw_bit;
      logic next_raw_bit;
      logic en_bit;
      logic next_en_bit;

      // A detected error in the same cycle as a clear still leaves its
      // flag set.
      always_comb begin
        next_raw_bit = raw_bit;
        if (wr_enabled && hwdata[g]) begin
          next_raw_bit = 1'b0;
        end
        if (wr_raw && hwdata[g]) begin
          next_raw_bit = 1'b1;
        end
        if (hw_events[g]) begin
          next_raw_bit = 1'b1;
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          raw_bit <= RST_FLAGS[g];
        end else begin
          raw_bit <= next_raw_bit;
        end
      end

      always_comb begin
        next_en_bit = en_bit;
        if (wr_en_set && hwdata[g]) begin
          next_en_bit = 1'b1;
        end
        if (wr_en_clr && hwdata[g]) begin
          next_en_bit = 1'b0;
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          en_bit <= RST_ENABLES[g];
        end else begin
          en_bit <= next_en_bit;
        end
      end

      assign raw_flags[g] = raw_bit;
      assign enables[g] = en_bit;
    end else begin : g_rsvd
      assign raw_flags[g] = 1'b0;
      assign enables[g] = 1'b0;
    end
  end

  // ************************************************************
  // Enabled flags and interrupt
  // ************************************************************
  // The interrupt is a plain OR of flops, so it follows a new flag in
  // the same cycle in which the flag becomes readable.
  assign enabled_flags = raw_flags & enables;
  assign irq = |enabled_flags;

  // ************************************************************
  // Read data
  // ************************************************************
  // Unmapped offsets read as zero and ignore writes
  always_comb begin
    read_value = '0;
    unique case (addr_q)
      OFS_SELECT: begin
        read_value = select_value;
      end
      OFS_ELAPSED: begin
        read_value = elapsed;
      end
      OFS_RAW: begin
        read_value = raw_flags;
      end
      OFS_ENABLED: begin
        read_value = enabled_flags;
      end
      OFS_EN_SET, OFS_EN_CLR: begin
        read_value = enables;
      end
      default: begin
        read_value = '0;
      end
    endcase
  end

  // Loaded only in the read wait cycle, so the value stands until the
  // next read.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (state == BUS_READ_WAIT) begin
      hrdata <= read_value;
    end
  end

endmodule : dpfis_top

/* File: verification/dpfis_top_asserts.sv */
// Port-level assertions for the filter select and interrupt status block
`timescale 1ns/100ps
module dpfis_top_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [dpfis_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [dpfis_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  input wire logic [dpfis_pkg::DATA_W-1:0] hrdata,
  input wire logic single_bit_ecc_event,
  input wire logic double_bit_ecc_event,
  input wire logic write_path_ecc_event,
  input wire logic bus_cmd_addr_error_event,
  input wire logic [dpfis_pkg::MST_W-1:0] counter_one_master_filter,
  input wire logic [dpfis_pkg::REG_W-1:0] counter_one_region_filter,
  input wire logic [dpfis_pkg::MST_W-1:0] counter_two_master_filter,
  input wire logic [dpfis_pkg::REG_W-1:0] counter_two_region_filter,
  input wire logic irq
);
  import dpfis_pkg::*;
  logic ph_act;
  logic ph_wr;
  logic [DEC_W-1:0] ph_ofs;
  logic wr_end;
  logic rd_end;
  logic any_ev;
  assign wr_end = ph_act && ph_wr && hready;
  assign rd_end = ph_act && !ph_wr && hready;
  assign any_ev = single_bit_ecc_event || double_bit_ecc_event || write_path_ecc_event
    || bus_cmd_addr_error_event;
  // ************************************************************
  // Data phase tracking
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_act <= 1'b0;
      ph_wr <= 1'b0;
      ph_ofs <= 8'h00;
    end else if (hready) begin
      ph_act <= hsel && htrans[1];
      ph_wr <= hwrite;
      ph_ofs <= haddr[DEC_W-1:0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ************************************************************
  // Properties
  // ************************************************************
  property p_m2; wr_end && ph_ofs == OFS_SELECT |=>
    counter_two_master_filter == $past(hwdata[31:24]); endproperty
  a_m2: assert property (p_m2) else $error("master two filter not loaded");
  property p_m1; wr_end && ph_ofs == OFS_SELECT |=>
    counter_one_master_filter == $past(hwdata[15:8]); endproperty
  a_m1: assert property (p_m1) else $error("master one filter not loaded");
  property p_r2; wr_end && ph_ofs == OFS_SELECT |=>
    counter_two_region_filter == $past(hwdata[19:16]); endproperty
  a_r2: assert property (p_r2) else $error("region two filter not loaded");
  property p_r1; wr_end && ph_ofs == OFS_SELECT |=>
    counter_one_region_filter == $past(hwdata[3:0]); endproperty
  a_r1: assert property (p_r1) else $error("region one filter not loaded");
  property p_hold; !(wr_end && ph_ofs == OFS_SELECT) |=> $stable({counter_one_master_filter,
    counter_one_region_filter, counter_two_master_filter, counter_two_region_filter});
  endproperty
  a_hold: assert property (p_hold) else $error("filters changed without write");
  property p_rise; $rose(irq) |-> $past(any_ev) || $past(wr_end && (ph_ofs == OFS_RAW
    || ph_ofs == OFS_EN_SET)); endproperty
  a_rise: assert property (p_rise) else $error("irq rose without cause");
  property p_fall; $fell(irq) |-> $past(wr_end && (ph_ofs == OFS_ENABLED
    || ph_ofs == OFS_EN_CLR)); endproperty
  a_fall: assert property (p_fall) else $error("irq fell without clear");
  property p_fres; rd_end && ph_ofs >= OFS_RAW && ph_ofs <= OFS_EN_CLR |->
    (hrdata & ~FLAG_MASK) == 32'h00000000; endproperty
  a_fres: assert property (p_fres) else $error("flag reserved bits not zero");
  property p_sres; rd_end && ph_ofs == OFS_SELECT |-> (hrdata & 32'h00F000F0) == 32'h0;
  endproperty
  a_sres: assert property (p_sres) else $error("select reserved bits not zero");
  property p_unm; rd_end && ph_ofs > OFS_EN_CLR |-> hrdata == 32'h00000000; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
endmodule : dpfis_top_asserts
bind dpfis_top dpfis_top_asserts u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .single_bit_ecc_event(single_bit_ecc_event),
  .double_bit_ecc_event(double_bit_ecc_event), .write_path_ecc_event(write_path_ecc_event),
  .bus_cmd_addr_error_event(bus_cmd_addr_error_event),
  .counter_one_master_filter(counter_one_master_filter),
  .counter_one_region_filter(counter_one_region_filter),
  .counter_two_master_filter(counter_two_master_filter),
  .counter_two_region_filter(counter_two_region_filter), .irq(irq));

/* File: verification/dpfis_top_tb.sv */
// Self-checking bench for the filter select and interrupt status block
`timescale 1ns/100ps
module dpfis_top_tb;
  import dpfis_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, irq;
  logic [1:0] htrans = 2'h0;
  logic [3:0] ev = 4'h0, f1r, f2r;
  logic [7:0] f1m, f2m;
  logic [31:0] haddr = 0, hwdata = 0, rd, st = 32'h00000062, r, m_sel = 0, m_raw = 0, m_en = 0;
  logic [31:0] e_last;
  logic [31:0] hrdata_w;
  int n_fail = 0, tests_run = 0, cyc = 0, c_last = -1;
  dpfis_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata_w), .hreadyout(hreadyout), .hresp(hresp), .single_bit_ecc_event(ev[3]),
    .double_bit_ecc_event(ev[2]), .write_path_ecc_event(ev[1]),
    .bus_cmd_addr_error_event(ev[0]), .counter_one_master_filter(f1m),
    .counter_one_region_filter(f1r), .counter_two_master_filter(f2m),
    .counter_two_region_filter(f2r), .irq(irq));
  initial forever #5 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      n_fail = n_fail + 1;
      end_sim();
    end
  end
  function logic [31:0] rnd();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction : rnd
  function logic [31:0] exp_rd(logic [7:0] a);
    case (a)
      OFS_SELECT: return m_sel;
      OFS_RAW: return m_raw;
      OFS_ENABLED: return m_raw & m_en;
      OFS_EN_SET, OFS_EN_CLR: return m_en;
      default: return 32'h00000000;
    endcase
  endfunction : exp_rd
  task chk(string nm, logic [31:0] e, logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task rdy;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata_w;
  endtask : rdy
  task bus(logic w, logic [31:0] a, logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    chk("hresp", 32'h0, {31'h0, hresp});
    if (w) begin
      case (a[7:0])
        OFS_SELECT: m_sel = d & 32'hFF0FFF0F;
        OFS_RAW: m_raw |= d & FLAG_MASK;
        OFS_ENABLED: m_raw &= ~d;
        OFS_EN_SET: m_en |= d & FLAG_MASK;
        OFS_EN_CLR: m_en &= ~d;
        default: ;
      endcase
    end else if (a[7:0] == OFS_ELAPSED) begin
      if (c_last >= 0) chk("elapsed", e_last + 32'(cyc - c_last), rd);
      e_last = rd;
      c_last = cyc;
    end else chk("rdata", exp_rd(a[7:0]), rd);
  endtask : bus
  task evt;
    r = rnd() & rnd();
    ev <= r[3:0];
    @(posedge hclk);
    ev <= 4'h0;
    m_raw |= {26'h0, r[3:1], 2'h0, r[0]};
    @(negedge hclk);
    chk("irq", {31'h0, |(m_raw & m_en)}, {31'h0, irq});
    chk("masters", {16'h0, m_sel[31:24], m_sel[15:8]}, {16'h0, f2m, f1m});
    chk("regions", {24'h0, m_sel[19:16], m_sel[3:0]}, {24'h0, f2r, f1r});
    @(posedge hclk);
  endtask : evt
  task end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 7; i++) bus(1'b0, 32'(i * 4), 32'h0);
    $display("reset values test done");
    for (int j = 0; j < 16; j++) begin
      r = rnd();
      bus(1'b1, OFS_SELECT, {r[31:20], 4'(j), r[15:4], 4'(15 - j)});
      bus(1'b0, OFS_SELECT, 32'h0);
      evt();
    end
    $display("region codes test done");
    for (int k = 0; k < 300; k++) begin
      r = rnd();
      bus(r[31], 32'((rnd() % 32'h7) << 2), rnd());
      evt();
    end
    $display("random traffic test done");
    end_sim();
  end
endmodule : dpfis_top_tb
